// >>> dv/nuc_array_model.sv
// Behavioural flash and EEPROM array answering the unlock controller
`timescale 1ns/1ns
`default_nettype none
module nuc_array_model import nuc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller side
    input wire logic arr_start,
    input wire logic arr_abort,
    input wire logic [ADDR_W-1:0] arr_addr,
    // Bench control
    input wire logic [7:0] dly,
    // Answers
    output logic arr_done,
    output logic [15:0] arr_rdata,
    output logic [LAT_IW-1:0] arr_lat_idx
);
    // ==========
    // Cycle timer
    int cnt;
    // Read data is a pattern of the address so a stale address shows up
    assign arr_rdata = arr_addr[15:0] ^ 16'h5A5A;
    // Duration varies per run; the controller may only learn of the end from arr_done
    always_ff @(posedge clk) begin
        arr_done <= 1'b0;
        arr_lat_idx <= rst ? 5'h00 : arr_lat_idx + 5'h01;
        if (rst || arr_abort) begin
            cnt <= 0;
        end else if (arr_start) begin
            cnt <= int'(dly) + 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            arr_done <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : nuc_array_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the unlock controller with a behavioural array
`timescale 1ns/1ns
`default_nettype none
module testbench import nuc_pkg::*; ;
    // ==========
    // Signals
    logic clk, rst, cyc, stb, we, ack, tr, twe, rv, emr, wdt, dn, st, ab, stall, df, busy_rd;
    logic [15:0] adr, trd, ard, twd, ld;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [23:0] ta, aa, x_addr;
    logic [6:0] op, x_op;
    logic [4:0] li, li_d;
    logic [7:0] dly;
    logic [31:0] q[$], tq[$];
    logic [15:0] lat[32];
    logic [6:0] ops[5] = '{OP_EE_BLOCK_PROG, OP_EE_BLOCK_ERASE, OP_EE_WORD_ERASE,
        OP_EE_WORD_PROG, OP_FLASH_ROW_ERASE};
    int n_errors, n_tests, n_st, n_ab, n, seed;

    nuc_ctrl #(.OP_NOM_CYCLES(50)) uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack),
        .wb_dat_o(rdat), .tbl_req(tr), .tbl_we(twe), .tbl_addr(ta), .tbl_wdata(twd),
        .tbl_rdata(trd), .tbl_rvalid(rv), .cpu_stall(stall), .ext_master_reset(emr),
        .watchdog_timeout(wdt), .arr_done(dn), .arr_rdata(ard), .arr_lat_idx(li),
        .arr_start(st), .arr_abort(ab), .arr_op(op), .arr_addr(aa), .arr_lat_data(ld),
        .op_done_flag(df));
    nuc_array_model arr (.clk(clk), .rst(rst), .arr_start(st), .arr_abort(ab), .arr_addr(aa),
        .dly(dly), .arr_done(dn), .arr_rdata(ard), .arr_lat_idx(li));

    // ==========
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic wb(input logic w, input logic [11:0] i, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge clk);
        {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'h3, 2'b00, i, 2'b00, 16'h0000, d};
        @(posedge clk);
        // Only the watchdog ends this wait; the latency is checked afterwards
        while (ack !== 1'b1) begin
            @(posedge clk);
            k++;
        end
        check("ack", 32'(k), 32'h1);
        {cyc, stb} <= 2'b00;
    endtask : wb

    task automatic rd(input logic [11:0] i, input logic [15:0] e);
        q.push_back({16'h0000, e});
        wb(1'b0, i, 16'h0000);
    endtask : rd

    task automatic tbl(input logic w, input logic [23:0] a, input logic [15:0] d);
        @(posedge clk);
        {tr, twe, ta, twd} <= {1'b1, w, a, d};
        x_addr = a;
        if (w) lat[a[5:1]] = d;
        else tq.push_back(busy_rd ? 32'h00000000 : {16'h0000, a[15:0] ^ 16'h5A5A});
        @(posedge clk);
        tr <= 1'b0;
    endtask : tbl

    // Keys are broken or interrupted on request to show the gate holds
    task automatic go(input logic [6:0] o, input int brk);
        x_op = o;
        wb(1'b1, IDX_CTL, 16'h4000 | 16'(o));
        wb(1'b1, IDX_KEY, brk == 1 ? 16'h0056 : 16'h0055);
        if (brk == 2) rd(IDX_ADRH, {8'h00, x_addr[23:16]});
        wb(1'b1, IDX_KEY, 16'h00AA);
        if (brk == 3) wb(1'b1, 12'h7F0, 16'h0000);
        wb(1'b1, IDX_CTL, 16'hC000 | 16'(o));
        repeat (2) @(posedge clk);
    endtask : go

    task automatic wait_done();
        int k;
        k = 0;
        while (df !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        check("done", 32'(df), 32'h1);
    endtask : wait_done

    // ==========
    // Monitor: results are compared against the oldest note
    always @(posedge clk) begin
        li_d <= li;
        if (ack === 1'b1 && we === 1'b0) check("reg", rdat, q.pop_front());
        if (rv === 1'b1) check("table", {16'h0000, trd}, tq.pop_front());
        if (ab === 1'b1) n_ab++;
        if (st === 1'b1) begin
            n_st++;
            check("op", 32'(op), 32'(x_op));
            check("addr", 32'(aa), 32'(x_addr));
            check("latch", 32'(ld), 32'(lat[li_d]));
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Far longer than the sequence needs
    initial begin
        #200000;
        n_errors++;
        conclude();
    end

    initial begin
        {rst, cyc, stb, we, sel, adr, wdat, tr, twe, ta, twd, emr, wdt, busy_rd} = '0;
        rst = 1'b1;
        dly = 8'h20;
        {x_addr, x_op, n_errors, n_tests, n_st, n_ab} = '0;
        foreach (lat[i]) lat[i] = 16'h0000;
        seed = $urandom(29);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_CTL, CTL_RESET);
        rd(IDX_KEY, 16'h0000);
        rd(12'h7F0, 16'h0000);
        // Permit and go in one write must not start
        wb(1'b1, IDX_KEY, 16'h0055);
        wb(1'b1, IDX_KEY, 16'h00AA);
        wb(1'b1, IDX_CTL, 16'hC044);
        rd(IDX_CTL, 16'h4044);
        // Sixteen latches, then a read that leaves the address
        n = int'($urandom % 128) * 32;
        for (int i = 0; i < 16; i++) tbl(1'b1, EE_FIRST + 24'(n + 2 * i), 16'($urandom));
        tbl(1'b0, EE_FIRST + 24'(n + 34), 16'h0000);
        repeat (3) @(posedge clk);
        rd(IDX_ADRL, x_addr[15:0]);
        rd(IDX_ADRH, {8'h00, x_addr[23:16]});
        foreach (ops[i]) begin
            // The word program reuses the word just erased and loads its latch first
            if (i > 0 && i != 3) begin
                x_addr = EE_FIRST + {12'h000, 11'($urandom), 1'b0};
                wb(1'b1, IDX_ADRL, x_addr[15:0]);
                wb(1'b1, IDX_ADRH, {8'h00, x_addr[23:16]});
            end
            if (i == 3) tbl(1'b1, x_addr, 16'($urandom));
            // Kept below the overdue threshold; the long cycle later covers that bit
            dly = 8'd12 + 8'($urandom % 30);
            n = n_st;
            go(ops[i], 0);
            rd(IDX_CTL, 16'hC000 | 16'(ops[i]));
            check("start", n_st, n + 1);
            check("stall", 32'(stall), 32'(ops[i][3:0] == OP_FLASH_NIBBLE));
            wb(1'b1, IDX_CTL, 16'h4000 | 16'(ops[i]));
            rd(IDX_CTL, 16'hC000 | 16'(ops[i]));
            wait_done();
            check("stall", 32'(stall), 32'h0);
            rd(IDX_CTL, 16'h4000 | 16'(ops[i]));
            rd(IDX_STAT, 16'h0005);
            wb(1'b1, IDX_STAT, 16'h0001);
            rd(IDX_STAT, 16'h0004);
        end
        // Broken, wrong or missing unlock; go alone must not start again
        n = n_st;
        for (int b = 1; b < 4; b++) go(OP_EE_WORD_PROG, b);
        wb(1'b1, IDX_CTL, 16'hC004);
        rd(IDX_CTL, 16'h4004);
        check("start", n_st, n);
        // Dropping permit mid-cycle
        dly = 8'd60;
        go(OP_EE_WORD_ERASE, 0);
        wb(1'b1, IDX_CTL, 16'h0044);
        rd(IDX_CTL, 16'h8044);
        busy_rd = 1'b1;
        tbl(1'b0, x_addr, 16'h0000);
        busy_rd = 1'b0;
        wait_done();
        rd(IDX_CTL, 16'h0044);
        rd(IDX_STAT, 16'h000D);
        // Reset events in mid-write
        for (int j = 0; j < 2; j++) begin
            dly = 8'd200;
            go(OP_EE_WORD_PROG, 0);
            @(posedge clk);
            {emr, wdt} <= j == 0 ? 2'b10 : 2'b01;
            @(posedge clk);
            {emr, wdt} <= 2'b00;
            rd(IDX_CTL, 16'h6004);
            rd(IDX_ADRL, x_addr[15:0]);
            check("abort", n_ab, j + 1);
            wb(1'b1, IDX_CTL, 16'h4004);
        end
        repeat (5) @(posedge clk);
        check("pending", 32'(q.size() + tq.size()), 32'h0);
        conclude();
    end
endmodule : testbench
`default_nettype wire

// >>> logic/nuc_ctrl.sv
// Unlock gate, control registers and write latches for flash and data EEPROM
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module nuc_ctrl import nuc_pkg::*; #(
    parameter int unsigned OP_NOM_CYCLES = OP_NOM_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // CPU table instruction port
    input wire logic tbl_req,
    input wire logic tbl_we,
    input wire logic [ADDR_W-1:0] tbl_addr,
    input wire logic [15:0] tbl_wdata,
    output logic [15:0] tbl_rdata,
    output logic tbl_rvalid,
    output logic cpu_stall,
    // Device reset events that may interrupt a write
    input wire logic ext_master_reset,
    input wire logic watchdog_timeout,
    // Array side
    input wire logic arr_done,
    input wire logic [15:0] arr_rdata,
    input wire logic [LAT_IW-1:0] arr_lat_idx,
    output logic arr_start,
    output logic arr_abort,
    output logic [OPSEL_W-1:0] arr_op,
    output logic [ADDR_W-1:0] arr_addr,
    output logic [15:0] arr_lat_data,
    output logic op_done_flag
);

    // =================================================================
    // State
    nuc_regs_t r;
    nuc_regs_t nx;

    logic acc;
    logic acc_wr;
    logic [11:0] idx;
    logic [15:0] lane_m;
    logic [15:0] ctl_old;
    logic [15:0] ctl_wr;
    logic abort_evt;
    logic is_flash;
    logic in_ee;
    logic [15:0] stat_word;

    assign acc = wb_cyc_i && wb_stb_i && !r.ack;
    assign acc_wr = acc && wb_we_i;
    assign idx = wb_adr_i[13:2];
    assign lane_m = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign ctl_old = {r.ctl.go, r.ctl.permit, r.ctl.abort, 4'h0, r.ctl.timing_option_bit, 1'b0, r.ctl.op_sel};
    assign ctl_wr = (ctl_old & ~lane_m) | (wb_dat_i[15:0] & lane_m);
    assign abort_evt = ext_master_reset || watchdog_timeout;
    assign is_flash = (r.ctl.op_sel[3:0] == OP_FLASH_NIBBLE);
    assign in_ee = (r.addr >= EE_FIRST) && (r.addr <= EE_LAST);
    assign stat_word = {12'h000, r.overdue, in_ee, r.ctl.go, r.done};

    // =================================================================
    // Next state
    always_comb begin
        nx = r;
        nx.ack = acc;
        nx.start = 1'b0;
        nx.kill = 1'b0;
        nx.trv = 1'b0;
        nx.rdpend = 1'b0;
        nx.lat_q = r.lat[arr_lat_idx];

        // Register reads; unmapped addresses answer zero
        if (acc) begin
            case (idx)
                IDX_CTL: nx.rdat = {16'h0000, ctl_old};
                IDX_ADRL: nx.rdat = {16'h0000, r.addr[15:0]};
                IDX_ADRH: nx.rdat = {24'h000000, r.addr[23:16]};
                IDX_STAT: nx.rdat = {16'h0000, stat_word};
                default: nx.rdat = 32'h00000000;
            endcase
        end

        // Unlock sequence; any access out of order drops it
        if (acc && r.st != ST_BUSY) begin
            nx.st = ST_IDLE;
            if (acc_wr && idx == IDX_KEY && wb_sel_i[0]) begin
                if (wb_dat_i[7:0] == KEY_FIRST) begin
                    nx.st = ST_KEY1;
                end else if (wb_dat_i[7:0] == KEY_SECOND && r.st == ST_KEY1) begin
                    nx.st = ST_ARMED;
                end
            end
        end

        // Software writes to address registers
        if (acc_wr && idx == IDX_ADRL) begin
            nx.addr[15:0] = (r.addr[15:0] & ~lane_m) | (wb_dat_i[15:0] & lane_m);
        end
        if (acc_wr && idx == IDX_ADRH && wb_sel_i[0]) begin
            nx.addr[23:16] = wb_dat_i[7:0];
        end

        // Control register write
        if (acc_wr && idx == IDX_CTL) begin
            nx.ctl.permit = ctl_wr[BIT_PERMIT];
            // Hardware sets this flag; software may clear it unless it sets now
            nx.ctl.abort = ctl_wr[BIT_ABORT];
            if (r.st != ST_BUSY) begin
                // Op select frozen mid-cycle so the array sees a steady code
                nx.ctl.timing_option_bit = ctl_wr[BIT_TIMING_OPTION_BIT];
                nx.ctl.op_sel = ctl_wr[OPSEL_W-1:0];
            end
            // Old permit is used, so one write setting both cannot start
            if (r.st == ST_ARMED && ctl_wr[BIT_GO] && r.ctl.permit && wb_sel_i[1]) begin
                nx.ctl.go = 1'b1;
                nx.st = ST_BUSY;
                nx.start = 1'b1;
                nx.cnt = '0;
                nx.overdue = 1'b0;
            end
        end

        // Done flag lives in the status register, write one to clear
        if (acc_wr && idx == IDX_STAT && wb_sel_i[0] && wb_dat_i[STAT_DONE]) begin
            nx.done = 1'b0;
        end

        // Table instructions: capture address, load latches, read data
        if (tbl_req) begin
            nx.addr = tbl_addr;
            if (tbl_we) begin
                nx.lat[tbl_addr[LAT_IW:1]] = tbl_wdata;
            end else begin
                nx.rdpend = 1'b1;
            end
        end
        if (r.rdpend) begin
            // Data read mid-cycle is unspecified; zero is returned
            nx.trd = r.ctl.go ? 16'h0000 : arr_rdata;
            nx.trv = 1'b1;
        end

        // Running cycle: completion comes from the array, not a count
        if (r.st == ST_BUSY) begin
            if (r.cnt != '1) begin
                nx.cnt = r.cnt + 1'b1;
            end
            if (32'(r.cnt) >= OP_NOM_CYCLES) begin
                nx.overdue = 1'b1;
            end
            if (abort_evt) begin
                nx.ctl.go = 1'b0;
                nx.ctl.abort = 1'b1;
                nx.kill = 1'b1;
                nx.st = ST_IDLE;
            end else if (arr_done) begin
                nx.ctl.go = 1'b0;
                nx.done = 1'b1;
                nx.st = ST_IDLE;
            end
        end else if (abort_evt) begin
            nx.st = ST_IDLE;
        end

        // Flash cycles hold the processor; EEPROM cycles leave it running.
        // The code in force next cycle is used, so a go write that also
        // changes the code stalls from its first busy cycle.
        nx.stall = nx.ctl.go && (nx.ctl.op_sel[3:0] == OP_FLASH_NIBBLE);
    end

    // =================================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.st <= ST_IDLE;
        end else begin
            r <= nx;
        end
    end

    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.rdat;
    assign tbl_rdata = r.trd;
    assign tbl_rvalid = r.trv;
    assign cpu_stall = r.stall;
    assign arr_start = r.start;
    assign arr_abort = r.kill;
    assign arr_op = r.ctl.op_sel;
    assign arr_addr = r.addr;
    assign arr_lat_data = r.lat_q;
    assign op_done_flag = r.done;

    // =================================================================
    // Assertions
    logic ctl_wr_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_wr_q <= 1'b0;
        end else begin
            ctl_wr_q <= acc_wr && idx == IDX_CTL;
        end
    end

    go_unlock_a: assert property (@(posedge clk) disable iff (rst)
        $rose(r.ctl.go) |-> $past(r.st == ST_ARMED) && arr_start)
        else $error("operation started without full unlock");

    key_order_a: assert property (@(posedge clk) disable iff (rst)
        $rose(r.st == ST_ARMED) |-> $past(r.st == ST_KEY1) && $past(acc_wr))
        else $error("armed without first key just before");

    go_sticky_a: assert property (@(posedge clk) disable iff (rst)
        r.ctl.go && !arr_done && !abort_evt |=> r.ctl.go)
        else $error("op_go cleared before completion");

    permit_gate_a: assert property (@(posedge clk) disable iff (rst)
        $rose(r.ctl.go) |-> $past(r.ctl.permit, 2))
        else $error("op_go set without earlier permit");

    done_sets_a: assert property (@(posedge clk) disable iff (rst)
        r.ctl.go && arr_done && !abort_evt |=> !r.ctl.go && op_done_flag ##1 !r.ctl.go)
        else $error("completion did not clear op_go and set done");

    abort_keep_a: assert property (@(posedge clk) disable iff (rst)
        r.ctl.go && abort_evt && !tbl_req && !acc_wr |=> r.ctl.abort && arr_abort
        && !r.ctl.go && $stable(arr_addr))
        else $error("interrupted write not flagged or address lost");

    permit_sw_a: assert property (@(posedge clk) disable iff (rst)
        $changed(r.ctl.permit) |-> ctl_wr_q)
        else $error("op_permit changed without a software write");

    stall_flash_a: assert property (@(posedge clk) disable iff (rst)
        $rose(r.ctl.go) && is_flash |-> cpu_stall)
        else $error("flash cycle did not stall the processor");

    read_busy_a: assert property (@(posedge clk) disable iff (rst)
        tbl_rvalid && $past(r.ctl.go) |-> tbl_rdata == 16'h0000)
        else $error("read during cycle returned array data");

    addr_cap_a: assert property (@(posedge clk) disable iff (rst)
        tbl_req |=> arr_addr == $past(tbl_addr))
        else $error("table address not captured");

    wb_ack_a: assert property (@(posedge clk) disable iff (rst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle");

    start_cov: cover property (@(posedge clk) disable iff (rst)
        r.st == ST_ARMED ##1 arr_start);
    done_cov: cover property (@(posedge clk) disable iff (rst)
        r.ctl.go ##1 op_done_flag && !r.ctl.go);
    abort_cov: cover property (@(posedge clk) disable iff (rst)
        arr_abort);
    break_cov: cover property (@(posedge clk) disable iff (rst)
        r.st == ST_KEY1 ##1 r.st == ST_IDLE);

endmodule : nuc_ctrl
`default_nettype wire

// >>> logic/nuc_pkg.sv
// Constants, types and state layout for the non-volatile memory unlock controller
// =====================================================================
// Notes on behaviour
// - Only a 0x55 then 0xAA key write, then setting op_go, starts an operation.
// - Operation address is nvm_addr_high bits 23:16 joined with nvm_addr_low 15:0.
// - Data EEPROM supports single-word and 16-word block read and write; reads here are single-word table reads only.
// - Data EEPROM spans 0x7FF000 to 0x7FFFFE, reached by table low accesses.
// - EEPROM write lasts about 2 ms; completion comes from array status.
// - CPU keeps running during EEPROM cycles; software waits before the next.
// - EEPROM reads during an erase or program cycle return unspecified data.
// - Software can set op_go but never clear it; hardware clears it.
// - op_permit clears at power-up; while clear no write may start.
// - External or watchdog reset during a write sets op_abort_flag; address kept.
// - Hardware never clears op_permit; only software writes change it.
// - Clearing op_permit after start does not affect the running cycle.
// - op_go sets only if op_permit was set by an earlier write.
// - Completion clears op_go and sets op_done_flag until software clears it.
// - Block erase: address points at block, control loaded with block-erase code.
// - Word erase: control loaded with word-erase code, then unlock and op_go.
// - Word update: erase, load write latch by table write, program, wait done.
// - Program-flash operation lasts nominally 2 ms and stalls the processor.
// - Address registers capture the last table instruction address; writable too.
// - EEPROM word program uses 0x4004; block program after sixteen latches 0x400A.
// - Write latches hold 32 words loaded in order from a 32-word boundary.
package nuc_pkg;

    // =================================================================
    // Register indices; the byte address is four times the index
    localparam logic [11:0] IDX_CTL = 12'h760;
    localparam logic [11:0] IDX_ADRL = 12'h762;
    localparam logic [11:0] IDX_ADRH = 12'h764;
    localparam logic [11:0] IDX_KEY = 12'h766;
    localparam logic [11:0] IDX_STAT = 12'h768;

    // =================================================================
    // Control register fields
    localparam int BIT_GO = 15;
    localparam int BIT_PERMIT = 14;
    localparam int BIT_ABORT = 13;
    localparam int BIT_TIMING_OPTION_BIT = 8;
    localparam int OPSEL_W = 7;
    localparam logic [15:0] CTL_RESET = 16'h0000;

    // Status register fields
    localparam int STAT_DONE = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_EEPROM = 2;
    localparam int STAT_OVERDUE = 3;

    // =================================================================
    // Keys and operation codes (low seven bits of the control word)
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [6:0] OP_FLASH_ROW_ERASE = 7'h41;
    localparam logic [6:0] OP_EE_BLOCK_ERASE = 7'h45;
    localparam logic [6:0] OP_EE_WORD_ERASE = 7'h44;
    localparam logic [6:0] OP_EE_WORD_PROG = 7'h04;
    localparam logic [6:0] OP_EE_BLOCK_PROG = 7'h0A;
    localparam logic [3:0] OP_FLASH_NIBBLE = 4'h1;

    // =================================================================
    // Memory geometry
    localparam int ADDR_W = 24;
    localparam int LAT_N = 32;
    localparam int LAT_IW = 5;
    localparam logic [23:0] EE_FIRST = 24'h7FF000;
    localparam logic [23:0] EE_LAST = 24'h7FFFFE;

    // =================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int OP_NOM_TIME_NS = 2000000;
    localparam int OP_NOM_CYC = OP_NOM_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_KEY1 = 4'h2,
        ST_ARMED = 4'h4,
        ST_BUSY = 4'h8
    } nuc_state_t;

    typedef struct packed {
        logic go;
        logic permit;
        logic abort;
        logic timing_option_bit;
        logic [OPSEL_W-1:0] op_sel;
    } nuc_ctl_t;

    typedef struct packed {
        nuc_state_t st;
        nuc_ctl_t ctl;
        logic [ADDR_W-1:0] addr;
        logic done;
        logic ack;
        logic [31:0] rdat;
        logic start;
        logic kill;
        logic stall;
        logic [LAT_N-1:0][15:0] lat;
        logic [15:0] lat_q;
        logic [15:0] trd;
        logic trv;
        logic rdpend;
        logic [CNT_W-1:0] cnt;
        logic overdue;
    } nuc_regs_t;

endpackage : nuc_pkg
